/* hw/tcc_pkg.sv */
/*
 Package for the timer capture/compare block: mode codes, reset values,
 interrupt source codes and the bundled CPU access carrier.
 Assumes a single 100 MHz clock and a byte-wide CPU port with strobes.
*/
// Contract
// - Capture copies 16-bit count on selected edge
// - Polarity bit selects rising or falling edge
// - Capture mode: capture interrupts, sets flag, keeps counting
// - Capture mode: reload interrupts, clears flag, continues
// - Restart mode: capture stores, interrupts, reloads 0001H
// - Restart mode: reload interrupts, clears flag, 0001H
// - Compare mode: match interrupts, count not reset
// - Compare mode: match toggles output when enabled
// - Compare mode: FFFFH wraps to 0000H
// - Compare mode counts prescaled clock only
// - Gated mode counts only while input active
// - Gated mode interrupts on deassertion and reload
// - Gated reload interrupts, loads 0001H, resumes if active
// - Gated reload toggles output when enabled
// - Gated written start count affects first pass only
// - Capture/compare idles until first edge, no interrupt
// - Later edges capture, interrupt, set flag, 0001H
// - Capture/compare match interrupts, clears flag, 0001H
// - Interrupt source field restricts event kinds
// - High byte read latches low byte while enabled
// - Reload high byte held until low byte write
package tcc_pkg;

    // ----------------------------------------------------------------
    // Modes and constants
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TCC_CAPTURE  = 3'h0,
        TCC_RESTART  = 3'h1,
        TCC_COMPARE  = 3'h2,
        TCC_GATED    = 3'h3,
        TCC_CAPCMP   = 3'h4
    } tcc_mode_e;

    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] COUNT_WRAP    = 16'h0000;
    localparam logic [15:0] COUNT_RESET   = 16'h0001;
    localparam logic [15:0] RELOAD_RESET  = 16'hffff;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [7:0]  PRESCALE_ONE  = 8'h00;

    // Interrupt source select: 0x both, 10 input only, 11 reload only
    localparam logic [1:0] ISRC_INPUT_ONLY  = 2'h2;
    localparam logic [1:0] ISRC_RELOAD_ONLY = 2'h3;

    // CPU byte access bundle
    typedef struct packed {
        logic       wrCountHigh;
        logic       wrCountLow;
        logic       wrReloadHigh;
        logic       wrReloadLow;
        logic       wrCaptureHigh;
        logic       wrCaptureLow;
        logic       rdCountHigh;
        logic       rdCountLow;
        logic [7:0] wdata;
    } tcc_cpu_s;

endpackage

/* hw/tcc_timer.sv */
/*
 Timer capture/compare core: capture, capture restart, compare, gated and
 capture/compare modes, with byte-wide count, reload and capture access.
 Assumes pin inputs are synchronous to mclk and software follows the
 disable, program, enable sequence.
*/
`timescale 1ns/1ps

module tcc_timer (
    input  wire logic              mclk,             // System clock, 100 MHz
    input  wire logic              rst,              // Async reset, high
    input  wire logic              timerEnable,      // Timer run enable
    input  wire tcc_pkg::tcc_mode_e modeSelect,      // Operating mode
    input  wire logic              modeSelectTopBit, // Upper mode bit
    input  wire logic [7:0]        prescaleDiv,      // Prescale minus one
    input  wire logic              inputPolaritySelect, // Edge / active level
    input  wire logic [1:0]        interruptSourceSelect, // Event filter
    input  wire logic              outputAltEnable,  // Output pin function on
    input  wire logic              timerIn,          // External timer input
    input  wire tcc_pkg::tcc_cpu_s cpu,              // CPU byte access
    output logic [7:0]             rdata,            // Read data
    output logic [15:0]            countValue,       // Live count
    output logic [15:0]            reloadValue,      // Reload / compare
    output logic [15:0]            captureValue,     // Captured count
    output logic                   captureCauseFlag, // Last irq was capture
    output logic                   timerIrq,         // One-cycle interrupt
    output logic                   timerOut          // Output pin level
);

    // ----------------------------------------------------------------
    // Input edge detection
    // ----------------------------------------------------------------
    logic       inPrev;
    logic       selEdge;
    logic       deassert;
    logic       inActive;
    logic       armed;
    logic       firstPass;
    logic       tick;
    logic [7:0] preCnt;
    logic [7:0] holdLow;
    logic [7:0] reloadHoldHigh;
    logic       capEv;
    logic       rldEv;
    logic       inEvIrq;
    logic       rldEvIrq;
    logic       atReload;
    logic [15:0] next_count;

    // Previous sample; input already synchronous to mclk
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            inPrev <= 1'b0;
        end else begin
            inPrev <= timerIn;
        end
    end

    // One event per transition, one cycle wide
    assign selEdge  = inputPolaritySelect ? (timerIn & ~inPrev)
                                          : (~timerIn & inPrev);
    assign inActive = (timerIn == inputPolaritySelect);
    assign deassert = (inPrev == inputPolaritySelect) & ~inActive;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Prescaled tick from the system clock, never from the pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            preCnt <= tcc_pkg::PRESCALE_ONE;
        end else if (!timerEnable || preCnt >= prescaleDiv) begin
            preCnt <= tcc_pkg::PRESCALE_ONE;
        end else begin
            preCnt <= preCnt + 8'h01;
        end
    end
    assign tick = timerEnable && (preCnt >= prescaleDiv);

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    assign atReload = (countValue == reloadValue);

    // Capture and reload events (capture on second and later edges in capture/compare)
    always_comb begin
        capEv = 1'b0;
        rldEv = 1'b0;
        if (timerEnable) begin
            case (modeSelect)
                tcc_pkg::TCC_CAPTURE: begin
                    capEv = selEdge;
                    rldEv = tick && atReload;
                end
                tcc_pkg::TCC_RESTART: begin
                    capEv = selEdge && modeSelectTopBit;
                    rldEv = tick && atReload && !capEv;
                end
                tcc_pkg::TCC_COMPARE: begin
                    rldEv = tick && atReload;
                end
                tcc_pkg::TCC_GATED: begin
                    rldEv = tick && atReload && inActive;
                end
                tcc_pkg::TCC_CAPCMP: begin
                    capEv = selEdge && armed;
                    rldEv = armed && tick && atReload && !capEv;
                end
                default: begin
                    capEv = 1'b0;
                    rldEv = 1'b0;
                end
            endcase
        end
    end

    // Input-type event: capture, or deassertion in gated mode
    assign inEvIrq  = capEv ||
                      (timerEnable && modeSelect == tcc_pkg::TCC_GATED && deassert);
    assign rldEvIrq = rldEv;

    // ----------------------------------------------------------------
    // Capture/compare arming
    // ----------------------------------------------------------------
    // First edge only starts the count, so it raises nothing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (!timerEnable || modeSelect != tcc_pkg::TCC_CAPCMP) begin
            armed <= 1'b0;
        end else if (selEdge) begin
            armed <= 1'b1;
        end
    end

    // Gated first pass marker; cleared by the first reload
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            firstPass <= 1'b1;
        end else if (!timerEnable) begin
            firstPass <= 1'b1;
        end else if (rldEv) begin
            firstPass <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_comb begin
        next_count = countValue;
        if (cpu.wrCountHigh) begin
            next_count = {cpu.wdata, countValue[7:0]};
        end else if (cpu.wrCountLow) begin
            next_count = {countValue[15:8], cpu.wdata};
        end else if (timerEnable) begin
            case (modeSelect)
                tcc_pkg::TCC_CAPTURE: begin
                    if (tick) begin
                        next_count = countValue + 16'h0001;
                    end
                end
                tcc_pkg::TCC_COMPARE: begin
                    if (tick) begin
                        next_count = (countValue == 16'hffff)
                                     ? tcc_pkg::COUNT_WRAP
                                     : countValue + 16'h0001;
                    end
                end
                tcc_pkg::TCC_GATED: begin
                    if (rldEv) begin
                        next_count = tcc_pkg::COUNT_RESTART;
                    end else if (tick && inActive) begin
                        next_count = countValue + 16'h0001;
                    end
                end
                tcc_pkg::TCC_RESTART, tcc_pkg::TCC_CAPCMP: begin
                    if (capEv || rldEv) begin
                        next_count = tcc_pkg::COUNT_RESTART;
                    end else if (tick && (armed || modeSelect == tcc_pkg::TCC_RESTART)) begin
                        next_count = countValue + 16'h0001;
                    end
                end
                default: begin
                    next_count = countValue;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            countValue <= tcc_pkg::COUNT_RESET;
        end else begin
            countValue <= next_count;
        end
    end

    // ----------------------------------------------------------------
    // Reload register with high byte staging
    // ----------------------------------------------------------------
    // Staging avoids a torn compare value between the two byte writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reloadHoldHigh <= tcc_pkg::RELOAD_RESET[15:8];
            reloadValue    <= tcc_pkg::RELOAD_RESET;
        end else begin
            if (cpu.wrReloadHigh) begin
                reloadHoldHigh <= cpu.wdata;
            end
            if (cpu.wrReloadLow) begin
                reloadValue <= {reloadHoldHigh, cpu.wdata};
            end
        end
    end

    // ----------------------------------------------------------------
    // Capture register
    // ----------------------------------------------------------------
    // Capture wins over a CPU write in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            captureValue <= tcc_pkg::CAPTURE_RESET;
        end else if (capEv) begin
            captureValue <= countValue;
        end else if (cpu.wrCaptureHigh) begin
            captureValue <= {cpu.wdata, captureValue[7:0]};
        end else if (cpu.wrCaptureLow) begin
            captureValue <= {captureValue[15:8], cpu.wdata};
        end
    end

    // ----------------------------------------------------------------
    // Cause flag, interrupt and output pin
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            captureCauseFlag <= 1'b0;
        end else if (capEv) begin
            captureCauseFlag <= 1'b1;
        end else if (rldEv && modeSelect != tcc_pkg::TCC_COMPARE) begin
            captureCauseFlag <= 1'b0;
        end
    end

    // Source field filters which event kind raises the pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= (inEvIrq && interruptSourceSelect != tcc_pkg::ISRC_RELOAD_ONLY) ||
                        (rldEvIrq && interruptSourceSelect != tcc_pkg::ISRC_INPUT_ONLY);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timerOut <= 1'b0;
        end else if (!timerEnable) begin
            timerOut <= inputPolaritySelect;     // Initial level while stopped
        end else if (outputAltEnable && rldEv &&
                     (modeSelect == tcc_pkg::TCC_COMPARE || modeSelect == tcc_pkg::TCC_GATED)) begin
            timerOut <= ~timerOut;
        end
    end

    // ----------------------------------------------------------------
    // Read path with low byte holding
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            holdLow <= 8'h00;
        end else if (cpu.rdCountHigh && timerEnable) begin
            holdLow <= countValue[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (cpu.rdCountHigh) begin
            rdata <= countValue[15:8];
        end else if (cpu.rdCountLow) begin
            rdata <= timerEnable ? holdLow : countValue[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence capSeen_s;
        capEv;
    endsequence

    property restartLoad_p;
        @(posedge mclk) disable iff (rst)
        (capEv && modeSelect == tcc_pkg::TCC_RESTART && !cpu.wrCountHigh && !cpu.wrCountLow)
        |=> countValue == 16'h0001;
    endproperty

    capStore_a: assert property (@(posedge mclk) disable iff (rst)
        capSeen_s |=> captureValue == $past(countValue))
        else $error("capture value not stored");
    restartLoad_a: assert property (restartLoad_p)
        else $error("restart count not 0001");
    capFlag_a: assert property (@(posedge mclk) disable iff (rst)
        capSeen_s |=> captureCauseFlag)
        else $error("cause flag not set");
    reloadFlag_a: assert property (@(posedge mclk) disable iff (rst)
        (rldEv && !capEv && modeSelect == tcc_pkg::TCC_CAPTURE) |=> !captureCauseFlag)
        else $error("cause flag not cleared");
    firstEdge_a: assert property (@(posedge mclk) disable iff (rst)
        (modeSelect == tcc_pkg::TCC_CAPCMP && !armed && selEdge) |=> !timerIrq)
        else $error("first edge raised irq");
    gateHold_a: assert property (@(posedge mclk) disable iff (rst)
        (modeSelect == tcc_pkg::TCC_GATED && !inActive && !cpu.wrCountHigh
         && !cpu.wrCountLow) |=> $stable(countValue))
        else $error("gated count moved");
    cmpWrap_a: assert property (@(posedge mclk) disable iff (rst)
        (modeSelect == tcc_pkg::TCC_COMPARE && timerEnable && tick && countValue == 16'hffff
         && !cpu.wrCountHigh && !cpu.wrCountLow) |=> countValue == 16'h0000)
        else $error("compare wrap wrong");
    irqFilter_a: assert property (@(posedge mclk) disable iff (rst)
        (interruptSourceSelect == tcc_pkg::ISRC_INPUT_ONLY && rldEv && !inEvIrq) |=> !timerIrq)
        else $error("reload irq not filtered");
    reloadStage_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu.wrReloadHigh && !cpu.wrReloadLow) |=> $stable(reloadValue))
        else $error("reload high leaked early");

    // Later gated passes ignore the written start and begin at 0001
    gatePass_a: assert property (@(posedge mclk) disable iff (rst)
        (modeSelect == tcc_pkg::TCC_GATED && !firstPass && rldEv && !cpu.wrCountHigh
         && !cpu.wrCountLow) |=> countValue == tcc_pkg::COUNT_RESTART)
        else $error("gated pass not restarted");
    cmpToggle_a: assert property (@(posedge mclk) disable iff (rst)
        (modeSelect == tcc_pkg::TCC_COMPARE && timerEnable && outputAltEnable && rldEv)
        |=> timerOut != $past(timerOut))
        else $error("compare match did not toggle");
    gateDrop_a: assert property (@(posedge mclk) disable iff (rst)
        (timerEnable && modeSelect == tcc_pkg::TCC_GATED && deassert
         && interruptSourceSelect != tcc_pkg::ISRC_RELOAD_ONLY) |=> timerIrq)
        else $error("deassertion raised no irq");
    lowHold_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu.rdCountHigh && timerEnable) |=> holdLow == $past(countValue[7:0]))
        else $error("low byte not held");

endmodule

/* tb/tcc_pin_model.sv */
/*
 Far-side model of the timer input pin: the bench asks for a level and the
 pin follows it one clock later, at a falling clock edge.
 Assumes one 100 MHz clock and that the pin is synchronous to it.
*/
`timescale 1ns/1ps

module tcc_pin_model (
    input  wire logic mclk,     // System clock
    input  wire logic rst,      // Async reset, high
    input  wire logic drvLevel, // Level asked for by the bench
    output logic      timerIn   // Driven pin level
);
    logic reqLevel; // Level taken at the rising edge

    // Request taken at the rising edge so the bench's own falling-edge
    // update never races the pin driver below
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            reqLevel <= 1'b0;
        end else begin
            reqLevel <= drvLevel;
        end
    end

    // ------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------
    // Moves only on the falling edge so the block samples a settled pin
    always @(negedge mclk or posedge rst) begin
        if (rst) begin
            timerIn <= 1'b0;
        end else begin
            timerIn <= reqLevel;
        end
    end
endmodule

/* tb/timer_capture_compare_gated_tb.sv */
/*
 Self-checking bench for the timer capture/compare core: expected events
 are queued by the driver and matched against each interrupt pulse.
 Assumes the pin model drives timerIn; prescale is one tick per clock
 except in the compare scenario, which ticks every second clock.
*/
`timescale 1ns/1ps

module timer_capture_compare_gated_tb;
    typedef struct {
        logic [1:0] flag;   // 0/1 exact, 2 unchanged, 3 free
        logic [1:0] cntMode; // 0 prev+1, 1 fixed, 2 free
        logic [15:0] cnt;
        logic       capNow; // Capture equals count of the edge cycle
        logic       tog;
    } tcc_note_s;
    logic mclk, rst, timerEnable, modeTop, pol, outAlt, drvLevel, timerIn;
    logic captureCauseFlag, timerIrq, timerOut, prevFlag, prevOut;
    tcc_pkg::tcc_mode_e modeSelect;
    logic [1:0] isrc;
    logic [7:0] preDiv;
    tcc_pkg::tcc_cpu_s cpu;
    logic [7:0] rdata;
    logic [15:0] countValue, reloadValue, captureValue, prevCount, prevCap, c;
    tcc_note_s expQ[$];
    tcc_note_s n;
    int errTotal = 0;
    int numChecks = 0;
    logic [31:0] seed = 32'd45;

    tcc_timer i_dut (.mclk(mclk), .rst(rst), .timerEnable(timerEnable),
        .modeSelect(modeSelect), .modeSelectTopBit(modeTop),
        .prescaleDiv(preDiv), .inputPolaritySelect(pol),
        .interruptSourceSelect(isrc), .outputAltEnable(outAlt), .timerIn(timerIn),
        .cpu(cpu), .rdata(rdata), .countValue(countValue), .reloadValue(reloadValue),
        .captureValue(captureValue), .captureCauseFlag(captureCauseFlag),
        .timerIrq(timerIrq), .timerOut(timerOut));
    tcc_pin_model i_pins (.mclk(mclk), .rst(rst), .drvLevel(drvLevel), .timerIn(timerIn));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp16(string nm, logic [15:0] e, logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp1(string nm, logic e, logic g);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic closeOut();
        if (errTotal == 0 && numChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One-cycle strobe; a free cycle follows so strobes never merge
    task automatic pulse(logic [7:0] sel, logic [7:0] d);
        @(negedge mclk);
        cpu = {sel, d};
        @(negedge mclk);
        cpu = '0;
    endtask
    task automatic note(logic [1:0] f, logic [1:0] cm, logic [15:0] v, logic cp, logic t);
        expQ.push_back('{f, cm, v, cp, t});
    endtask
    task automatic idle(int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic waitDone();
        int k;
        k = 0;
        while (expQ.size() != 0 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        if (expQ.size() != 0) begin
            errTotal++;
            $display("wrong value pending irq expected 0 seen %0d", expQ.size());
            expQ.delete();
        end
    endtask
    // Disable, program, clear capture, enable
    task automatic setup(tcc_pkg::tcc_mode_e m, logic p, logic [15:0] s, logic [15:0] r);
        @(negedge mclk);
        timerEnable = 1'b0;
        modeSelect = m;
        modeTop = (m == tcc_pkg::TCC_RESTART);
        pol = p;
        pulse(8'h80, s[15:8]);
        pulse(8'h40, s[7:0]);
        pulse(8'h20, r[15:8]);
        pulse(8'h10, r[7:0]);
        pulse(8'h08, 8'h00);
        pulse(8'h04, 8'h00);
        timerEnable = 1'b1;
    endtask

    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Each irq pulse consumes the oldest note; a stray pulse is a mismatch
    always @(negedge mclk) begin
        if (!rst && timerIrq === 1'b1) begin
            if (expQ.size() == 0) begin
                cmp1("timerIrq", 1'b0, timerIrq);
            end else begin
                n = expQ.pop_front();
                if (n.flag < 2) cmp1("flag", n.flag[0], captureCauseFlag);
                if (n.flag == 2) cmp1("flag", prevFlag, captureCauseFlag);
                if (n.cntMode == 0) cmp16("count", prevCount + 16'h0001, countValue);
                if (n.cntMode == 1) cmp16("count", n.cnt, countValue);
                cmp16("capture", n.capNow ? prevCount : prevCap, captureValue);
                cmp1("timerOut", n.tog ? ~prevOut : prevOut, timerOut);
            end
        end
        prevCount = countValue;
        prevCap = captureValue;
        prevFlag = captureCauseFlag;
        prevOut = timerOut;
    end
    initial begin
        repeat (6000) @(posedge mclk);
        errTotal++;
        closeOut();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        timerEnable = 1'b0;
        modeSelect = tcc_pkg::TCC_CAPTURE;
        {modeTop, pol, outAlt, drvLevel} = 4'h0;
        isrc = 2'h0;
        preDiv = tcc_pkg::PRESCALE_ONE;
        cpu = '0;
        idle(20);
        rst = 1'b0;
        cmp16("count", tcc_pkg::COUNT_RESET, countValue);
        cmp16("reload", tcc_pkg::RELOAD_RESET, reloadValue);
        cmp16("capture", tcc_pkg::CAPTURE_RESET, captureValue);
        cmp16("rdata", 16'h0000, {8'h00, rdata});
        cmp1("flag", 1'b0, captureCauseFlag);
        // Reload high byte waits for the low byte write
        pulse(8'h20, 8'h12);
        cmp16("reload", 16'hffff, reloadValue);
        pulse(8'h10, 8'h34);
        cmp16("reload", 16'h1234, reloadValue);
        // Capture on rising edge, then latched 16-bit read
        setup(tcc_pkg::TCC_CAPTURE, 1'b1, 16'h0001, 16'h0100);
        idle(3 + xs() % 16);
        note(2'd1, 2'd0, 16'h0000, 1'b1, 1'b0);
        drvLevel = 1'b1;
        waitDone();
        c = countValue + 16'h0001;
        pulse(8'h02, 8'h00);
        cmp16("rdHigh", {8'h00, c[15:8]}, {8'h00, rdata});
        idle(3);
        pulse(8'h01, 8'h00);
        cmp16("rdLow", {8'h00, c[7:0]}, {8'h00, rdata});
        // Falling edge captures, rising edge is ignored
        setup(tcc_pkg::TCC_CAPTURE, 1'b0, 16'h0001, 16'h0100);
        idle(3 + xs() % 16);
        note(2'd1, 2'd0, 16'h0000, 1'b1, 1'b0);
        drvLevel = 1'b0;
        waitDone();
        drvLevel = 1'b1;
        idle(10);
        // Reload in capture mode keeps counting and clears the flag
        setup(tcc_pkg::TCC_CAPTURE, 1'b1, 16'h0001, 16'h0010);
        drvLevel = 1'b0;
        note(2'd0, 2'd0, 16'h0000, 1'b0, 1'b0);
        waitDone();
        // Input-only source: reload is silent, capture still interrupts
        isrc = tcc_pkg::ISRC_INPUT_ONLY;
        setup(tcc_pkg::TCC_CAPTURE, 1'b1, 16'h0001, 16'h0010);
        idle(40);
        note(2'd1, 2'd0, 16'h0000, 1'b1, 1'b0);
        drvLevel = 1'b1;
        waitDone();
        isrc = 2'h0;
        // Restart mode: capture then reload, both back to 0001
        drvLevel = 1'b0;
        setup(tcc_pkg::TCC_RESTART, 1'b1, 16'h0001, 16'h0040);
        idle(3 + xs() % 16);
        note(2'd1, 2'd1, 16'h0001, 1'b1, 1'b0);
        note(2'd0, 2'd1, 16'h0001, 1'b0, 1'b0);
        drvLevel = 1'b1;
        waitDone();
        // Compare mode wraps past ffff and ignores pin noise
        outAlt = 1'b1;
        preDiv = 8'h01;
        setup(tcc_pkg::TCC_COMPARE, 1'b0, 16'hfff0, 16'h0010);
        note(2'd2, 2'd0, 16'h0000, 1'b0, 1'b1);
        repeat (20) begin
            @(negedge mclk);
            drvLevel = xs() % 2;
        end
        waitDone();
        preDiv = tcc_pkg::PRESCALE_ONE;
        // Gated: written start only for the first pass, toggle on reload
        drvLevel = 1'b0;
        setup(tcc_pkg::TCC_GATED, 1'b1, 16'h0005, 16'h0008);
        note(2'd0, 2'd1, 16'h0001, 1'b0, 1'b1);
        note(2'd0, 2'd1, 16'h0001, 1'b0, 1'b1);
        drvLevel = 1'b1;
        waitDone();
        idle(3);
        note(2'd3, 2'd2, 16'h0000, 1'b0, 1'b0);
        drvLevel = 1'b0;
        waitDone();
        c = countValue;
        idle(5);
        cmp16("count", c, countValue);
        // Reload-only source hides the deassertion event
        isrc = tcc_pkg::ISRC_RELOAD_ONLY;
        drvLevel = 1'b1;
        idle(2);
        drvLevel = 1'b0;
        idle(10);
        isrc = 2'h0;
        outAlt = 1'b0;
        // Capture/compare: idle until first edge, which stays silent
        setup(tcc_pkg::TCC_CAPCMP, 1'b1, 16'h0001, 16'h0020);
        idle(10);
        cmp16("count", 16'h0001, countValue);
        drvLevel = 1'b1;
        idle(3 + xs() % 8);
        drvLevel = 1'b0;
        idle(3 + xs() % 8);
        note(2'd1, 2'd1, 16'h0001, 1'b1, 1'b0);
        note(2'd0, 2'd1, 16'h0001, 1'b0, 1'b0);
        drvLevel = 1'b1;
        waitDone();
        idle(5);
        closeOut();
    end
endmodule
